// >>> common/ncsb_consts.vh
// constants for the primary control/status register bank
// Notes on behaviour
// - receive-done flag bit 10 sets when a receive ring entry status is written.
// - transmit-done flag bit 9 sets when a transmit ring entry status is written.
// - done flags clear on write of one; zero writes ignored; software never sets.
// - with irq enable set, any done flag setting raises an interrupt request.
// - setup-done flag bit 8 sets only after full init block fetch and latch.
// - summary bit 7 is OR of babble, missed, memory error and done flags.
// - interrupt pin low exactly when summary and enable bit 6 both one.
// - summary clears on reset or stop, and falls when all causes clear.
// - interrupt enable is read/write, cleared by reset or stop.
// - receiver-on bit 5 drops after init with rx disable, or on memory error.
// - receiver-on sets on start when rx disable mode bit is zero.
// - transmitter-on bit 4 sets on initialize or on start, in both cases only when tx enabled.
// - transmitter-on drops on underflow/retry, memory error, or init with tx disable.
// - both on indicators read-only, cleared by reset or stop.
// - software may set transmit demand bit 3 to skip the 1.6 ms poll wait.
// - transmit demand clears after ring access, reset or stop.
// - writing one to stop bit 2 halts and clears like reset; zero ignored.
// - stop stays set until start or initialize is written, which clear it.
// - start, initialize and stop written together leave only stop set.
// - stop aborts all activity at once, no clean boundary.
// - start with initialize runs initialization first, then start.
// - error summary is OR of babble, collision, missed and memory error.
`ifndef NCSB_CONSTS_VH
`define NCSB_CONSTS_VH
// ****************************************
// bit positions
// ****************************************
`define NCSB_BIT_ERR   15
`define NCSB_BIT_OVERLONG 14
`define NCSB_BIT_COLLTEST 13
`define NCSB_BIT_MISS  12
`define NCSB_BIT_BUSTO 11
`define NCSB_BIT_RXD   10
`define NCSB_BIT_TXD   9
`define NCSB_BIT_SETUP 8
`define NCSB_BIT_IRQ   7
`define NCSB_BIT_IEN   6
`define NCSB_BIT_RX_ACTIVE 5
`define NCSB_BIT_TX_ACTIVE 4
`define NCSB_BIT_POLL  3
`define NCSB_BIT_STOP  2
`define NCSB_BIT_RUN   1
`define NCSB_BIT_INIT  0
// ****************************************
// reset and timing
// ****************************************
`define NCSB_STOP_RESET 1'h1
`define NCSB_POLL_US    1600
`define NCSB_CLK_MHZ    50
`endif

// >>> logic/ncsb_ctrl_status.v
// control/status bits 15..0 of the primary register: flags, enables, on states, stop
`timescale 1ns/100ps
`include "ncsb_consts.vh"
module ncsb_ctrl_status #(
    parameter POLL_CYCLES = `NCSB_POLL_US * `NCSB_CLK_MHZ
) (
    // clock and reset
    input  wire        mclk,
    input  wire        reset,
    // register port
    input  wire        reg_wr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    // controller events
    input  wire        rx_status_done,
    input  wire        tx_status_done,
    input  wire        setup_loaded,
    input  wire        rx_disable_cfg,
    input  wire        tx_disable_cfg,
    input  wire        tx_fail,
    input  wire        tx_ring_accessed,
    input  wire        overlong_tx_error,
    input  wire        collision_test_error,
    input  wire        missed_frame,
    input  wire        bus_timeout_error,
    // controller commands
    output reg         setup_busy,
    output wire        tx_poll_tick,
    output wire        tx_poll_now,
    output wire        halt,
    output wire        irq_pin_n
);
    // ****************************************
    // state
    // ****************************************
    reg        rx_done_reg;
    reg        tx_done_reg;
    reg        setup_done_reg;
    reg        irq_enable_reg;
    reg        rx_active_reg;
    reg        tx_active_reg;
    reg        poll_reg;
    reg        stop_reg;
    reg        run_reg;
    reg        init_reg;
    reg        overlong_reg;
    reg        colltest_reg;
    reg        miss_reg;
    reg        bus_timeout_reg;
    reg        run_pend_reg;
    reg [31:0] poll_cnt_reg;
    wire       w_stop;
    wire       w_run;
    wire       w_init;
    wire       kill;
    wire       setup_fin;
    wire       run_now;
    wire       irq_summary;
    wire       err_summary;

    // write-one-to-clear with set winning the same cycle
    function wc;
        input cur;
        input set;
        input clr_bit;
        begin
            wc = set | (cur & ~(reg_wr & clr_bit));
        end
    endfunction

    // ****************************************
    // command decode
    // ****************************************
    assign w_stop       = reg_wr & reg_wdata[`NCSB_BIT_STOP];
    assign w_run        = reg_wr & reg_wdata[`NCSB_BIT_RUN] & ~w_stop;
    assign w_init       = reg_wr & reg_wdata[`NCSB_BIT_INIT] & ~w_stop;
    // stop acts in the write cycle itself, no waiting for a clean boundary
    assign kill         = w_stop;
    assign setup_fin    = setup_busy & setup_loaded;
    // a start written in the very completion cycle still counts
    assign run_now      = run_pend_reg | w_run;
    assign irq_summary  = overlong_reg | miss_reg | bus_timeout_reg
                        | rx_done_reg | tx_done_reg | setup_done_reg;
    assign err_summary  = overlong_reg | colltest_reg | miss_reg | bus_timeout_reg;
    assign irq_pin_n    = ~(irq_summary & irq_enable_reg);
    assign halt         = stop_reg;
    assign tx_poll_now  = poll_reg;
    assign tx_poll_tick = (poll_cnt_reg == 32'h0) & ~stop_reg;

    // ****************************************
    // done flags
    // ****************************************
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            rx_done_reg <= 1'h0;
        end else if (kill) begin
            rx_done_reg <= 1'h0;
        end else begin
            rx_done_reg <= wc(rx_done_reg, rx_status_done & ~stop_reg,
                              reg_wdata[`NCSB_BIT_RXD]);
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            tx_done_reg <= 1'h0;
        end else if (kill) begin
            tx_done_reg <= 1'h0;
        end else begin
            tx_done_reg <= wc(tx_done_reg, tx_status_done & ~stop_reg,
                              reg_wdata[`NCSB_BIT_TXD]);
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            setup_done_reg <= 1'h0;
        end else if (kill) begin
            setup_done_reg <= 1'h0;
        end else begin
            setup_done_reg <= wc(setup_done_reg, setup_fin,
                                 reg_wdata[`NCSB_BIT_SETUP]);
        end
    end

    // ****************************************
    // error flags
    // ****************************************
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            overlong_reg <= 1'h0;
        end else if (kill) begin
            overlong_reg <= 1'h0;
        end else begin
            overlong_reg <= wc(overlong_reg, overlong_tx_error,
                               reg_wdata[`NCSB_BIT_OVERLONG]);
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            colltest_reg <= 1'h0;
        end else if (kill) begin
            colltest_reg <= 1'h0;
        end else begin
            colltest_reg <= wc(colltest_reg, collision_test_error,
                               reg_wdata[`NCSB_BIT_COLLTEST]);
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            miss_reg <= 1'h0;
        end else if (kill) begin
            miss_reg <= 1'h0;
        end else begin
            miss_reg <= wc(miss_reg, missed_frame, reg_wdata[`NCSB_BIT_MISS]);
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            bus_timeout_reg <= 1'h0;
        end else if (kill) begin
            bus_timeout_reg <= 1'h0;
        end else begin
            bus_timeout_reg <= wc(bus_timeout_reg, bus_timeout_error,
                                  reg_wdata[`NCSB_BIT_BUSTO]);
        end
    end

    // ****************************************
    // interrupt enable
    // ****************************************
    // plain read/write: every word written reloads it, except a stop word, which clears it
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_enable_reg <= 1'h0;
        end else if (kill) begin
            irq_enable_reg <= 1'h0;
        end else if (reg_wr) begin
            irq_enable_reg <= reg_wdata[`NCSB_BIT_IEN];
        end
    end

    // ****************************************
    // stop, start, initialize
    // ****************************************
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            stop_reg <= `NCSB_STOP_RESET;
        end else if (kill) begin
            stop_reg <= 1'h1;
        end else if (w_run | w_init) begin
            stop_reg <= 1'h0;
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            run_reg <= 1'h0;
        end else if (kill) begin
            run_reg <= 1'h0;
        end else if (w_run) begin
            run_reg <= 1'h1;
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            init_reg <= 1'h0;
        end else if (kill) begin
            init_reg <= 1'h0;
        end else if (w_init) begin
            init_reg <= 1'h1;
        end
    end

    // init fetch in progress; it ends on the load even when a bus
    // timeout falls in the same cycle, but a timeout with no load leaves it busy until a later load, stop or reset
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            setup_busy <= 1'h0;
        end else if (kill) begin
            setup_busy <= 1'h0;
        end else if (w_init) begin
            setup_busy <= 1'h1;
        end else if (setup_fin) begin
            setup_busy <= 1'h0;
        end
    end

    // start waits behind a pending initialization
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            run_pend_reg <= 1'h0;
        end else if (kill) begin
            run_pend_reg <= 1'h0;
        end else if (setup_fin) begin
            run_pend_reg <= 1'h0;
        end else if (w_run & (w_init | setup_busy)) begin
            run_pend_reg <= 1'h1;
        end
    end

    // ****************************************
    // transmit poll
    // ****************************************
    // ring access beats a demand written the same cycle
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            poll_reg <= 1'h0;
        end else if (kill) begin
            poll_reg <= 1'h0;
        end else if (tx_ring_accessed) begin
            poll_reg <= 1'h0;
        end else if (reg_wr & reg_wdata[`NCSB_BIT_POLL]) begin
            poll_reg <= 1'h1;
        end
    end

    // free poll timer, restarted after each ring access
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            poll_cnt_reg <= 32'h0;
        end else if (kill) begin
            poll_cnt_reg <= 32'h0;
        end else if (tx_ring_accessed | (poll_cnt_reg == 32'h0)) begin
            poll_cnt_reg <= POLL_CYCLES - 32'h1;
        end else begin
            poll_cnt_reg <= poll_cnt_reg - 32'h1;
        end
    end

    // ****************************************
    // on indicators, one means enabled
    // ****************************************
    // memory error wins over every other update
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            rx_active_reg <= 1'h0;
        end else if (kill) begin
            rx_active_reg <= 1'h0;
        end else if (bus_timeout_error) begin
            rx_active_reg <= 1'h0;
        end else if (setup_fin) begin
            if (rx_disable_cfg | ~run_now) begin
                rx_active_reg <= ~rx_disable_cfg & rx_active_reg;
            end else begin
                rx_active_reg <= 1'h1;
            end
        end else if (w_run & ~w_init & ~setup_busy) begin
            rx_active_reg <= ~rx_disable_cfg;
        end
    end

    // a transmit failure beats a start in the same cycle
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            tx_active_reg <= 1'h0;
        end else if (kill) begin
            tx_active_reg <= 1'h0;
        end else if (bus_timeout_error) begin
            tx_active_reg <= 1'h0;
        end else if (setup_fin) begin
            if (tx_disable_cfg) begin
                tx_active_reg <= 1'h0;
            end
        end else if (tx_fail) begin
            tx_active_reg <= 1'h0;
        end else if (w_run & ~w_init & ~setup_busy) begin
            tx_active_reg <= ~tx_disable_cfg;
        end else if (w_init & ~tx_disable_cfg) begin
            tx_active_reg <= 1'h1;
        end
    end

    // ****************************************
    // read back
    // ****************************************
    always @* begin
        reg_rdata = {err_summary, overlong_reg, colltest_reg, miss_reg, bus_timeout_reg,
                     rx_done_reg, tx_done_reg, setup_done_reg, irq_summary,
                     irq_enable_reg, rx_active_reg, tx_active_reg, poll_reg, stop_reg,
                     run_reg, init_reg};
    end
endmodule

// >>> verif/ncsb_ctrl_status_sva.sv
// concurrent checks on the control/status register bank ports
`timescale 1ns/100ps
module ncsb_ctrl_status_sva (
    // clock, reset, register port
    input wire        mclk, reset, reg_wr,
    input wire [15:0] reg_wdata, reg_rdata,
    // events and commands
    input wire        rx_status_done, tx_ring_accessed, bus_timeout_error,
    input wire        setup_busy, tx_poll_now, halt, irq_pin_n
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    property p_pin; irq_pin_n == !(reg_rdata[7] && reg_rdata[6]); endproperty
    a_pin: assert property (p_pin) else $error("irq pin wrong");
    property p_sum; reg_rdata[7] == |{reg_rdata[14], reg_rdata[12:8]}; endproperty
    a_sum: assert property (p_sum) else $error("summary wrong");
    property p_err; reg_rdata[15] == |reg_rdata[14:11]; endproperty
    a_err: assert property (p_err) else $error("error summary wrong");
    // a stop in the same cycle may win, so it is left out here
    property p_rxd;
        rx_status_done && !halt && !(reg_wr && reg_wdata[2]) |=> reg_rdata[10];
    endproperty
    a_rxd: assert property (p_rxd) else $error("rx done not set");
    property p_w1c; reg_wr && reg_wdata[10] && !rx_status_done |=> !reg_rdata[10]; endproperty
    a_w1c: assert property (p_w1c) else $error("rx done not cleared");
    property p_stop; reg_wr && reg_wdata[2] |=> halt && reg_rdata[10:0] == 11'h004; endproperty
    a_stop: assert property (p_stop) else $error("stop did not clear");
    property p_hold; halt && !(reg_wr && |reg_wdata[1:0]) |=> halt; endproperty
    a_hold: assert property (p_hold) else $error("stop left early");
    property p_init;
        halt && reg_wr && reg_wdata[0] && !reg_wdata[2] |=> !halt && setup_busy;
    endproperty
    a_init: assert property (p_init) else $error("init did not start");
    property p_busto; bus_timeout_error |=> !reg_rdata[5] && !reg_rdata[4]; endproperty
    a_busto: assert property (p_busto) else $error("on bits kept");
    property p_poll; tx_ring_accessed && !(reg_wr && reg_wdata[3]) |=> !tx_poll_now; endproperty
    a_poll: assert property (p_poll) else $error("demand kept");
endmodule
bind ncsb_ctrl_status ncsb_ctrl_status_sva u_sva (.mclk(mclk), .reset(reset), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_status_done(rx_status_done),
    .tx_ring_accessed(tx_ring_accessed), .bus_timeout_error(bus_timeout_error),
    .setup_busy(setup_busy), .tx_poll_now(tx_poll_now), .halt(halt), .irq_pin_n(irq_pin_n));

// >>> verif/net_ctrl_status_irq_bits_test.sv
// self-checking bench for the control/status register bank
`timescale 1ns/100ps
module net_ctrl_status_irq_bits_test;
    // ****************************************
    // stimulus, model and checks
    // ****************************************
    reg         mclk = 0, reset = 1, reg_wr = 0, rdis = 0, tdis = 0;
    reg  [15:0] reg_wdata = 16'h0, mdl = 16'h0004;
    reg  [8:0]  ev = 9'h0;
    wire [15:0] reg_rdata;
    wire        setup_busy, tx_poll_now, halt, irq_pin_n;
    integer     err_total = 0, cmp_count = 0, i;
    always #10 mclk = ~mclk;
    ncsb_ctrl_status #(.POLL_CYCLES(16)) dut (.mclk(mclk), .reset(reset), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_status_done(ev[0]),
        .tx_status_done(ev[1]), .setup_loaded(ev[2]), .rx_disable_cfg(rdis),
        .tx_disable_cfg(tdis), .tx_fail(ev[3]), .tx_ring_accessed(ev[4]),
        .overlong_tx_error(ev[5]), .collision_test_error(ev[6]), .missed_frame(ev[7]),
        .bus_timeout_error(ev[8]), .setup_busy(setup_busy), .tx_poll_tick(),
        .tx_poll_now(tx_poll_now), .halt(halt), .irq_pin_n(irq_pin_n));
    task chk(input [15:0] s, input [15:0] x);
        begin
            cmp_count = cmp_count + 1;
            if (s !== x) begin
                err_total = err_total + 1;
                $display("Error at %0t: seen %h expected %h", $time, s, x);
            end
        end
    endtask
    task look(input [63:0] name);
        begin
            chk(reg_rdata, mdl);
            chk({irq_pin_n, tx_poll_now, halt}, {~(mdl[7] & mdl[6]), mdl[3:2]});
            $display("test %0s done", name);
        end
    endtask
    // word and events go in together, so set-versus-clear races are reachable
    task drive(input [15:0] d, input [8:0] e);
        begin
            @(negedge mclk);
            reg_wr = (d != 16'h0);
            reg_wdata = d;
            ev = e;
            @(negedge mclk);
            reg_wr = 0;
            ev = 9'h0;
        end
    endtask
    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, err_total);
            if (err_total == 0 && cmp_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        repeat (2000) @(posedge mclk);
        err_total = err_total + 1;
        give_verdict;
    end
    initial begin
        i = $urandom(32'hfc895c7c);
        repeat (12) @(negedge mclk);
        reset = 0;
        look("reset");
        i = $urandom;
        tdis = i[0];
        drive(16'h0001, 9'h0);
        mdl = tdis ? 16'h0001 : 16'h0011;
        chk({15'h0, setup_busy}, 16'h0001);
        look("init");
        drive(16'h0, 9'h004);
        mdl = mdl | 16'h0180;
        chk({15'h0, setup_busy}, 16'h0000);
        look("setup");
        drive(16'h0040, 9'h0);
        mdl = mdl | 16'h0040;
        look("enable");
        drive(16'h0140, 9'h0);
        mdl = mdl & ~16'h0180;
        look("clear");
        tdis = 0;
        drive(16'h0042, 9'h0);
        mdl = mdl | 16'h0032;
        look("run");
        for (i = 0; i < 2; i = i + 1) begin
            drive((16'h0400 >> i) | 16'h0040, 9'h001 << i);
            mdl = mdl | (16'h0400 >> i) | 16'h0080;
            look("event");
            drive((16'h0400 >> i) | 16'h0040, 9'h0);
            mdl = mdl & ~((16'h0400 >> i) | 16'h0080);
            look("eventclr");
        end
        drive(16'h0048, 9'h0);
        mdl = mdl | 16'h0008;
        look("poll");
        drive(16'h0, 9'h010);
        mdl = mdl & ~16'h0008;
        look("polled");
        drive(16'h0, 9'h040);
        mdl = mdl | 16'ha000;
        look("colltest");
        drive(16'h0, 9'h008);
        mdl = mdl & ~16'h0010;
        look("txfail");
        drive(16'h0, 9'h1a0);
        mdl = (mdl | 16'h5880) & ~16'h0020;
        look("errors");
        drive(16'h0007, 9'h0);
        mdl = 16'h0004;
        look("stop");
        drive(16'h0003, 9'h0);
        mdl = 16'h0013;
        drive(16'h0, 9'h004);
        mdl = 16'h01b3;
        look("initrun");
        drive(16'h0001, 9'h0);
        chk({15'h0, setup_busy}, 16'h0001);
        drive(16'h0, 9'h104);
        mdl = (mdl | 16'h8800) & ~16'h0030;
        chk({15'h0, setup_busy}, 16'h0000);
        look("initfail");
        give_verdict;
    end
endmodule
